// ---- core/vfp_pkg.sv ----
// Package for the regulator fault supervision block
package vfp_pkg;
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_OCLIM = 8'h04;
  localparam logic [7:0] OFS_UVLIM = 8'h08;
  localparam logic [7:0] OFS_LIVE = 8'h0c;
  localparam logic [7:0] OFS_HIST = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_REL = 8'h18;
  localparam logic [7:0] OFS_STATE = 8'h1c;
  localparam int CFG_MARGIN = 0;
  localparam int CFG_RELEASE = 3;
  localparam int CFG_START = 4;
  localparam int CFG_GUARD = 6;
  localparam int CFG_UVADC = 7;
  localparam int CFG_DROOP = 8;
  localparam int CFG_OCMODE = 9;
  localparam int CFG_PHMODE = 11;
  localparam int CFG_BW = 13;
  localparam int OCL_SLOW = 8;
  localparam int F_OV = 0;
  localparam int F_UV = 1;
  localparam int F_FOC = 2;
  localparam int F_SOC = 3;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] OCLIM_RST = 32'h00ff_ff3e;
  localparam logic [31:0] UVLIM_RST = 32'h0000_012c;
  localparam logic [31:0] REL_RST = 32'h0000_012c;
  localparam logic [12:0] MARGIN_STEP_MV = 13'h0032;
  localparam logic [12:0] UV_ADC_MV = 13'h00f8;
  localparam logic [12:0] START_TRIP_MV [4] = '{13'h09c4, 13'h04b0, 13'h04fb, 13'h0546};
  localparam logic [1:0] OCM_SHUT = 2'h0;
  localparam logic [1:0] OCM_HIC2 = 2'h1;
  localparam logic [1:0] OCM_HICINF = 2'h2;
  localparam logic [1:0] HIC_RETRIES = 2'h2;
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMPLE_US = 100;
  localparam int SAMPLE_CYC = CLK_HZ / 1_000_000 * SAMPLE_US;
  localparam int HICCUP_MS = 20;
  localparam int HICCUP_CYC_DEF = CLK_HZ / 1000 * HICCUP_MS;
  localparam int SHIFT_BW0 = 14;

  typedef enum logic [1:0] {ST_RUN, ST_OFF, ST_SHUT} vfp_run_t;

  typedef struct packed {
    logic [11:0] vout_mv;
    logic [11:0] setpoint_mv;
    logic [11:0] droop_mv;
    logic [7:0] phase_amp_max;
    logic [15:0] total_amp;
    logic uv_cmp;
    logic enabled;
    logic soft_start;
    logic vid_moving;
    logic vid_down;
  } vfp_sense_t;

  typedef struct packed {
    logic lowside_on;
    logic switching;
    logic restart;
    logic shutdown;
  } vfp_drive_t;
endpackage : vfp_pkg

// ---- core/vfp_fault.sv ----
// Fault supervision with AHB-Lite register slave
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module vfp_fault
  import vfp_pkg::*;
#(
  parameter int HICCUP_CYC = HICCUP_CYC_DEF
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire vfp_sense_t sense,
  output vfp_drive_t drive,
  output logic irq
);
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] oclim;
    logic [31:0] uvlim;
    logic [31:0] rel;
    logic [3:0] mask;
    logic [3:0] hist;
    logic [3:0] live;
    logic ov_hold;
    vfp_run_t run;
    logic [1:0] retries;
    logic [31:0] timer;
    logic [15:0] tick;
    logic [31:0] avg;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    vfp_drive_t drv;
  } vfp_state_t;

  vfp_state_t s;
  vfp_state_t next_s;

  logic [12:0] ov_level;
  logic [12:0] uv_level;
  logic [12:0] vout;
  logic [8:0] oc_level;
  logic ov_active;
  logic oc_active;
  logic ov_now;
  logic uv_now;
  logic foc_now;
  logic soc_now;
  logic trip;
  logic [3:0] events;
  logic [4:0] bw_shift;
  logic [31:0] sample;
  logic [31:0] wmask;
  logic take;

  always_comb
  begin
    vout = {1'b0, sense.vout_mv};
    // Trip level relative to setpoint, absolute while soft-starting
    if (sense.soft_start)
    begin
      ov_level = START_TRIP_MV[s.cfg[CFG_START +: 2]];
    end
    else
    begin
      ov_level = {1'b0, sense.setpoint_mv}
        + 13'(MARGIN_STEP_MV * 13'({10'h000, s.cfg[CFG_MARGIN +: 3]} + 13'h0001));
    end
    ov_active = (sense.enabled || s.cfg[CFG_GUARD]) && !sense.vid_down;
    ov_now = ov_active && (vout > ov_level);
    // Comparator path subtracts margin and optionally droop
    uv_level = {1'b0, sense.setpoint_mv} - {1'b0, s.uvlim[11:0]}
      - (s.cfg[CFG_DROOP] ? {1'b0, sense.droop_mv} : 13'h0000);
    if (s.cfg[CFG_UVADC])
    begin
      uv_now = sense.enabled && (vout < UV_ADC_MV);
    end
    else
    begin
      // Digital compare backs up the comparator; a wrapped level never trips
      uv_now = sense.enabled && !sense.soft_start
        && (sense.uv_cmp || (!uv_level[12] && (vout < uv_level)));
    end
    // Phase mode 1 doubles, 2 quadruples the per-phase limit
    oc_level = {3'b000, s.oclim[5:0]} << s.cfg[CFG_PHMODE +: 2];
    oc_active = sense.enabled && !sense.soft_start && !sense.vid_moving;
    foc_now = oc_active && ({1'b0, sense.phase_amp_max} > oc_level);
    soc_now = oc_active && (s.avg[31:16] > s.oclim[OCL_SLOW +: 16]);
    trip = uv_now || foc_now || soc_now;
    events = {soc_now, foc_now, uv_now, ov_now};
    bw_shift = 5'(SHIFT_BW0) - {2'b00, s.cfg[CFG_BW +: 3]};
    sample = {sense.total_amp, 16'h0000};
    wmask = 32'hffff_ffff;
  end

  assign take = hsel && hready && htrans[1];

  always_comb
  begin
    next_s = s;
    next_s.drv.restart = 1'b0;
    next_s.live = events;
    next_s.hist = s.hist | events;
    // Averaging filter, one step per sample tick
    if (s.tick == 16'(SAMPLE_CYC - 1))
    begin
      next_s.tick = 16'h0000;
      if (sample >= s.avg)
      begin
        next_s.avg = s.avg + ((sample - s.avg) >> bw_shift);
      end
      else
      begin
        next_s.avg = s.avg - ((s.avg - sample) >> bw_shift);
      end
    end
    else
    begin
      next_s.tick = s.tick + 16'h0001;
    end
    // Low-side clamp: latch forever or hold until below release
    if (ov_now)
    begin
      next_s.ov_hold = 1'b1;
    end
    else if (s.cfg[CFG_RELEASE] && (vout < {1'b0, s.rel[11:0]}))
    begin
      next_s.ov_hold = 1'b0;
    end
    case (s.run)
      ST_RUN:
      begin
        if (trip)
        begin
          case (s.cfg[CFG_OCMODE +: 2])
            OCM_HICINF:
            begin
              next_s.run = ST_OFF;
              next_s.timer = 32'h0000_0000;
            end
            OCM_HIC2:
            begin
              if (s.retries == HIC_RETRIES)
              begin
                next_s.run = ST_SHUT;
              end
              else
              begin
                next_s.run = ST_OFF;
                next_s.retries = s.retries + 2'h1;
                next_s.timer = 32'h0000_0000;
              end
            end
            default:
            begin
              next_s.run = ST_SHUT;
            end
          endcase
        end
      end
      ST_OFF:
      begin
        // Off time lets the stage cool before a fresh soft-start
        if (s.timer == 32'(HICCUP_CYC - 1))
        begin
          next_s.run = ST_RUN;
          next_s.drv.restart = 1'b1;
        end
        else
        begin
          next_s.timer = s.timer + 32'h0000_0001;
        end
      end
      ST_SHUT:
      begin
        next_s.run = ST_SHUT;
      end
      default:
      begin
        next_s.run = ST_SHUT;
      end
    endcase
    next_s.drv.lowside_on = next_s.ov_hold;
    next_s.drv.switching = (next_s.run == ST_RUN) && !next_s.ov_hold;
    next_s.drv.shutdown = (next_s.run == ST_SHUT);
    // Register bus, write data phase
    if (s.wr_pend)
    begin
      case (s.wr_addr)
        OFS_CFG: next_s.cfg = hwdata & wmask;
        OFS_OCLIM: next_s.oclim = hwdata;
        OFS_UVLIM: next_s.uvlim = hwdata;
        OFS_REL: next_s.rel = hwdata;
        OFS_MASK: next_s.mask = hwdata[3:0];
        // Write-one clear; a fault in the same cycle wins
        OFS_HIST: next_s.hist = (s.hist & ~hwdata[3:0]) | events;
        default:
        begin
        end
      endcase
    end
    next_s.wr_pend = take && hwrite;
    next_s.wr_addr = {haddr[7:2], 2'b00};
    if (take && !hwrite)
    begin
      case ({haddr[7:2], 2'b00})
        OFS_CFG: next_s.rdata = s.cfg;
        OFS_OCLIM: next_s.rdata = s.oclim;
        OFS_UVLIM: next_s.rdata = s.uvlim;
        OFS_LIVE: next_s.rdata = {28'h000_0000, s.live};
        OFS_HIST: next_s.rdata = {28'h000_0000, s.hist};
        OFS_MASK: next_s.rdata = {28'h000_0000, s.mask};
        OFS_REL: next_s.rdata = s.rel;
        OFS_STATE: next_s.rdata = {26'h000_0000, s.retries, 2'(s.run), s.ov_hold, 1'b0};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.cfg <= CFG_RST;
      s.oclim <= OCLIM_RST;
      s.uvlim <= UVLIM_RST;
      s.rel <= REL_RST;
      s.run <= ST_RUN;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign drive = s.drv;
  assign irq = |(s.hist & s.mask);
endmodule : vfp_fault
`default_nettype wire

// ---- dv/vfp_fault_checker.sv ----
// Port assertions for the fault block
`timescale 1ns/1ns
`default_nettype none
module vfp_fault_checker
  import vfp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire vfp_sense_t sense,
  input wire vfp_drive_t drive
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_taken;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_taken <= 1'b0;
    else
      rd_taken <= hsel && hready && htrans[1] && !hwrite;
  end
  // Largest margin is 400mV, so this level trips in every setting
  chk_ov_clamp_on: assert property (sense.enabled && !sense.vid_down && !sense.soft_start &&
    sense.vout_mv > {1'b0, sense.setpoint_mv} + 13'h0190 |=> drive.lowside_on)
    else $error("no clamp on overvoltage");
  // Vout kept clear of every soft-start trip level and the fixed level
  chk_soft_no_trip: assert property (drive.switching && sense.enabled && sense.soft_start &&
    sense.vout_mv >= 12'h00f8 && sense.vout_mv < 12'h04b0 |=> drive.switching)
    else $error("trip during soft-start");
  chk_restart_pulse: assert property (drive.restart |=> !drive.restart)
    else $error("restart longer than one cycle");
  chk_restart_after: assert property (drive.restart |-> !$past(drive.switching))
    else $error("restart without stop");
  chk_shut_holds: assert property (drive.shutdown |=> drive.shutdown)
    else $error("shutdown released");
  chk_shut_quiet: assert property (drive.shutdown |-> !drive.switching && !drive.restart)
    else $error("switching in shutdown");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or okay");
  chk_rdata_stands: assert property (!rd_taken |-> $stable(hrdata))
    else $error("read data moved");
endmodule : vfp_fault_checker
bind vfp_fault vfp_fault_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense(sense),
  .drive(drive));
`default_nettype wire

// ---- dv/vfp_stage_model.sv ----
// Power stage model feeding the sense bundle
`timescale 1ns/1ns
`default_nettype none
module vfp_stage_model
  import vfp_pkg::*;
(
  input wire vfp_sense_t knob,
  input wire vfp_drive_t drive,
  output vfp_sense_t sense
);
  // A stopped stage carries no current, so a hiccup relieves the trip
  always_comb
  begin
    sense = knob;
    if (!drive.switching)
    begin
      sense.phase_amp_max = 8'h00;
      sense.total_amp = 16'h0000;
    end
  end
endmodule : vfp_stage_model
`default_nettype wire

// ---- dv/vfp_fault_tb_top.sv ----
// Testbench for the fault block
`timescale 1ns/1ns
`default_nettype none
module vfp_fault_tb_top
  import vfp_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  vfp_sense_t knob, sense;
  vfp_drive_t drive;
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  localparam logic [7:0] OFS [7] = '{OFS_CFG, OFS_OCLIM, OFS_UVLIM, OFS_REL, OFS_MASK, OFS_HIST, 8'h20};
  localparam logic [31:0] RV [7] = '{CFG_RST, OCLIM_RST, UVLIM_RST, REL_RST, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000};
  vfp_fault #(.HICCUP_CYC(20)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense(sense), .drive(drive), .irq(irq));
  vfp_stage_model stage_u (.knob(knob), .drive(drive), .sense(sense));
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // One idle cycle first, so a read never meets the previous write
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic ov(input logic [11:0] v, input logic e);
    knob.vout_mv <= v;
    repeat (3) @(posedge hclk);
    chk("lowside_on", 32'(e), 32'(drive.lowside_on));
  endtask : ov
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (4000) @(posedge hclk);
    num_errors++;
    print_verdict();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    knob = '0;
    knob.vout_mv = 12'h03e8;
    knob.setpoint_mv = 12'h03e8;
    knob.phase_amp_max = 8'h0a;
    knob.enabled = 1'b1;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b0, OFS[i], 32'h0000_0000);
      chk("reg_reset", RV[i], q);
    end
    $display("test reset_values done");
    bus(1'b1, OFS_CFG, 32'h0000_000f);
    bus(1'b1, OFS_REL, 32'h0000_0384);
    ov(12'h0578, 1'b0);
    ov(12'h0579, 1'b1);
    bus(1'b0, OFS_LIVE, 32'h0000_0000);
    chk("live", 32'h0000_0001, q);
    ov(12'h0320, 1'b0);
    bus(1'b0, OFS_LIVE, 32'h0000_0000);
    chk("live", 32'h0000_0000, q);
    bus(1'b1, OFS_HIST, 32'h0000_0000);
    bus(1'b0, OFS_HIST, 32'h0000_0000);
    chk("hist", 32'h0000_0001, q);
    ov(12'h0579, 1'b1);
    ov(12'h0320, 1'b0);
    knob.vid_down <= 1'b1;
    @(posedge hclk);
    ov(12'h0579, 1'b0);
    ov(12'h03e8, 1'b0);
    knob.vid_down <= 1'b0;
    $display("test overvoltage done");
    bus(1'b1, OFS_MASK, 32'h0000_0001);
    @(posedge hclk);
    chk("irq", 32'h0000_0001, 32'(irq));
    bus(1'b1, OFS_HIST, 32'h0000_0001);
    @(posedge hclk);
    chk("irq", 32'h0000_0000, 32'(irq));
    bus(1'b0, OFS_HIST, 32'h0000_0000);
    chk("hist", 32'h0000_0000, q);
    $display("test interrupt done");
    bus(1'b1, OFS_CFG, 32'h0000_0a00);
    knob.soft_start <= 1'b1;
    @(posedge hclk);
    knob.phase_amp_max <= 8'hc8;
    bus(1'b0, OFS_LIVE, 32'h0000_0000);
    chk("live", 32'h0000_0000, q);
    knob.phase_amp_max <= 8'h7c;
    @(posedge hclk);
    knob.soft_start <= 1'b0;
    bus(1'b0, OFS_LIVE, 32'h0000_0000);
    chk("live", 32'h0000_0000, q);
    knob.phase_amp_max <= 8'h7d;
    n = 0;
    for (int i = 0; i < 300 && drive.shutdown !== 1'b1; i++)
    begin
      @(posedge hclk);
      n += int'(drive.restart === 1'b1);
    end
    chk("restarts", 32'h0000_0002, 32'(n));
    chk("shutdown", 32'h0000_0001, 32'(drive.shutdown));
    bus(1'b0, OFS_HIST, 32'h0000_0000);
    chk("hist", 32'h0000_0004, q);
    $display("test overcurrent done");
    knob.phase_amp_max <= 8'h0a;
    knob.enabled <= 1'b0;
    knob.vout_mv <= 12'h0a00;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, OFS_CFG, 32'h0000_0008);
    ov(12'h0a00, 1'b0);
    bus(1'b1, OFS_CFG, 32'h0000_0048);
    ov(12'h0a00, 1'b1);
    ov(12'h0100, 1'b0);
    bus(1'b1, OFS_CFG, 32'h0000_0080);
    knob.vout_mv <= 12'h0f8;
    knob.enabled <= 1'b1;
    repeat (3) @(posedge hclk);
    bus(1'b0, OFS_LIVE, 32'h0000_0000);
    chk("live", 32'h0000_0000, q);
    knob.vout_mv <= 12'h0f7;
    repeat (3) @(posedge hclk);
    chk("shutdown", 32'h0000_0001, 32'(drive.shutdown));
    bus(1'b0, OFS_LIVE, 32'h0000_0000);
    chk("live", 32'h0000_0002, q);
    $display("test guard and undervoltage done");
    print_verdict();
  end
endmodule : vfp_fault_tb_top
`default_nettype wire
